// [rtl/irq_mask_params.svh]
// Register offsets, field positions and reset values for the interrupt enable/pending block.
// Assumes an AXI4-Lite slave with 32-bit data; registers sit in the low byte.
`ifndef IRQ_MASK_PARAMS_SVH
`define IRQ_MASK_PARAMS_SVH

// Printed register indices; 0xF09 is not a multiple of four, so byte address = index * 4
`define ENABLE_INDEX 12'hF08
`define PENDING_INDEX 12'hF09
`define ENABLE_ADDR 14'h3C20
`define PENDING_ADDR 14'h3C24
`define VECTOR_INDEX_ADDR 14'h0000

// Field positions shared by enable and pending registers
`define BIT_EXT_PIN_A 0
`define BIT_EXT_PIN_B 1
`define BIT_EXT_PIN_C 2
`define BIT_WAKEUP_TIMER 3
`define BIT_FIRST_TIMER 4
`define BIT_SECOND_TIMER 5
`define BIT_TOUCH_KEY 6
`define BIT_SERIAL_BUS 7

// Reset values and vectors
`define ENABLE_RESET 8'h00
`define PENDING_RESET 8'h00
`define RESET_VECTOR 12'h000
`define SHARED_IRQ_VECTOR 12'h001

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/irq_mask_pkg.sv]
// Types for the interrupt enable/pending block.
// Assumes the params header is included by the modules that need numbers.
package irq_mask_pkg;

  // Eight event sources, one bit each
  typedef logic [7:0] source_vec_t;

  // Write channel sequencing state, one-hot
  typedef enum logic [1:0]
  {
    wr_idle = 2'b01,
    wr_resp = 2'b10
  } wr_state_e;

endpackage

// [rtl/pending_flags.sv]
// Sticky pending flags for the eight event sources.
// Assumes source events are one-cycle pulses synchronous to clock.
`include "irq_mask_params.svh"

module pending_flags
  import irq_mask_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Events and software clear
  input wire source_vec_t events,
  input wire logic clear_write,
  input wire source_vec_t clear_data,
  // Flag state
  output source_vec_t flags
);

  // Set by hardware, cleared by a 0 in a software write; set beats clear
  // set until cleared
  always_ff @(posedge clock)
  begin
    if (rst)
      flags <= `PENDING_RESET;
    else if (clear_write)
      flags <= (flags & clear_data) | events;
    else
      flags <= flags | events;
  end

  // Flag holds once set without a clear
  a_flag_sticky : assert property (@(posedge clock) disable iff (rst)
    (!clear_write |=> ((flags & $past(flags)) == $past(flags))))
    else $error("pending flag dropped without a clear");

  // Event always wins over a simultaneous clear
  a_event_wins : assert property (@(posedge clock) disable iff (rst)
    (1'b1 |=> ((flags & $past(events)) == $past(events))))
    else $error("event lost on pending flag");

  // Writing 1 never changes a flag
  a_one_keeps : assert property (@(posedge clock) disable iff (rst)
    (clear_write && events == 8'h00 |=> flags == ($past(flags) & $past(clear_data))))
    else $error("clear write affected wrong flags");

endmodule

// [rtl/interrupt_enable_mask.sv]
// Interrupt enable mask and shared request for an 8-bit controller core.
// Assumes AXI4-Lite with one outstanding write and read; events are one-cycle pulses.
//
// What this block does
// - Enable bit 6 gates touch key event
// - Enable bit 2 gates external pin c
// - Enable bit 1 gates external pin b
// - Writing zero clears only that flag
// - One shared entry, flags stay readable
// - Accepted interrupt branches to shared vector
// - Hardware sets flag until software clears
//
// The AXI4-Lite slave port was left to the implementer.
`include "irq_mask_params.svh"

module interrupt_enable_mask
  import irq_mask_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Source events, one-cycle pulses
  input wire logic serial_bus_event,
  input wire logic touch_key_event,
  input wire logic second_timer_event,
  input wire logic first_timer_event,
  input wire logic wakeup_timer_event,
  input wire logic ext_pin_c_irq,
  input wire logic ext_pin_b_irq,
  input wire logic ext_pin_a_irq,
  // Core interrupt entry
  output logic core_irq,
  input wire logic core_irq_accept,
  output logic [11:0] core_vector,
  output logic core_vector_valid
);

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  source_vec_t source_enable_register;
  source_vec_t pending_flag_register;
  source_vec_t events;
  source_vec_t masked;
  wr_state_e wr_state;
  logic [13:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic clear_write;
  logic [1:0] wr_sel;
  logic wr_lane0;
  logic [7:0] wr_byte;

  function automatic logic [1:0] decode(input logic [13:0] addr);
    // Bit 0: enable register, bit 1: pending register
    decode = {addr == `PENDING_ADDR, addr == `ENABLE_ADDR};
  endfunction

  // Gather events in shared bit order
  assign events = {serial_bus_event, touch_key_event, second_timer_event, first_timer_event,
                   wakeup_timer_event, ext_pin_c_irq, ext_pin_b_irq, ext_pin_a_irq};

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data taken in either order; held until both arrive
  assign s_axi_awready = !aw_held && wr_state == wr_idle;
  assign s_axi_wready = !w_held && wr_state == wr_idle;
  assign do_write = wr_state == wr_idle && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

  // Take the held half if there is one, else the half on the bus this cycle
  assign wr_sel = decode(aw_held ? aw_addr : s_axi_awaddr);
  assign wr_lane0 = w_held ? w_strb[0] : s_axi_wstrb[0];
  assign wr_byte = w_held ? w_data[7:0] : s_axi_wdata[7:0];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 14'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Response one cycle after both halves are in
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_state <= wr_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      unique case (wr_state)
        wr_idle:
        begin
          if (do_write)
          begin
            wr_state <= wr_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
          end
        end
        wr_resp:
        begin
          if (s_axi_bready)
          begin
            wr_state <= wr_idle;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Enable register, low byte lane only
  // touch key gate
  always_ff @(posedge clock)
  begin
    if (rst)
      source_enable_register <= `ENABLE_RESET;
    else if (do_write && wr_sel[0] && wr_lane0)
      source_enable_register <= wr_byte;
  end

  assign clear_write = do_write && wr_sel[1] && wr_lane0;

  pending_flags flags_u
  (
    .clock(clock),
    .rst(rst),
    .events(events),
    .clear_write(clear_write),
    .clear_data(wr_byte),
    .flags(pending_flag_register)
  );

  // ****************************************************************
  // Read channel
  // ****************************************************************
  // flags readable for polling
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      unique case (decode(s_axi_araddr))
        2'b01: s_axi_rdata <= {24'h000000, source_enable_register};
        2'b10: s_axi_rdata <= {24'h000000, pending_flag_register};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************************
  // Core request and vector
  // ****************************************************************
  assign masked = pending_flag_register & source_enable_register;

  always_ff @(posedge clock)
  begin
    if (rst)
      core_irq <= 1'b0;
    else
      core_irq <= |masked;
  end

  // shared vector on acceptance; reset vector in every other cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_vector <= `RESET_VECTOR;
      core_vector_valid <= 1'b0;
    end
    else
    begin
      core_vector_valid <= core_irq && core_irq_accept;
      core_vector <= (core_irq && core_irq_accept) ? `SHARED_IRQ_VECTOR : `RESET_VECTOR;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_touch_gate : assert property (@(posedge clock) disable iff (rst)
    (!source_enable_register[6] && masked[5:0] == 6'h00 && masked[7] == 1'b0 |=> !core_irq))
    else $error("touch key request while masked");

  a_pin_c_gate : assert property (@(posedge clock) disable iff (rst)
    (pending_flag_register[2] && source_enable_register[2] |=> core_irq))
    else $error("pin c enabled flag gave no request");

  a_pin_b_gate : assert property (@(posedge clock) disable iff (rst)
    (pending_flag_register[1] && source_enable_register[1] |=> core_irq))
    else $error("pin b enabled flag gave no request");

  a_request_tie : assert property (@(posedge clock) disable iff (rst)
    (core_irq == $past(|(pending_flag_register & source_enable_register))))
    else $error("request does not follow masked flags");

  a_vector_shared : assert property (@(posedge clock) disable iff (rst)
    (core_irq && core_irq_accept |=> core_vector_valid && core_vector == 12'h001))
    else $error("accepted interrupt not sent to shared vector");

  a_read_flags : assert property (@(posedge clock) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `PENDING_ADDR |=>
      s_axi_rvalid && s_axi_rdata[7:0] == $past(pending_flag_register)))
    else $error("pending flags read back wrong");

  a_enable_write : assert property (@(posedge clock) disable iff (rst)
    (do_write && !aw_held && !w_held && s_axi_awaddr == `ENABLE_ADDR && s_axi_wstrb[0]
      |=> source_enable_register == $past(s_axi_wdata[7:0])))
    else $error("enable register write lost");

  a_clear_one : assert property (@(posedge clock) disable iff (rst)
    (clear_write && events == 8'h00 && !w_held
      |=> pending_flag_register == ($past(pending_flag_register) & $past(s_axi_wdata[7:0]))))
    else $error("clear write touched other flags");

endmodule

// [bench/core_model.sv]
// Behavioural processor core at the shared interrupt entry.
// Assumes core_irq and core_vector_valid come registered from the mask block.
module core_model
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Interrupt entry
  input wire logic core_irq,
  input wire logic core_vector_valid,
  input wire logic [1:0] lag,
  output logic core_irq_accept
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  logic in_service;

  // Accept after a chosen lag, then hold off until the vector lands
  // single shared entry
  always_ff @(posedge clock)
  begin
    core_irq_accept <= 1'b0;
    if (rst)
    begin
      wait_cnt <= 2'h0;
      in_service <= 1'b0;
    end
    else if (in_service)
      // Give up the wait if the request fell before the vector could come
      in_service <= !core_vector_valid && core_irq;
    else if (core_irq && wait_cnt == lag)
    begin
      core_irq_accept <= 1'b1;
      in_service <= 1'b1;
      wait_cnt <= 2'h0;
    end
    else
      wait_cnt <= core_irq ? wait_cnt + 2'h1 : 2'h0;
  end
endmodule

// [bench/test_interrupt_enable_mask.sv]
// Self-checking bench for the interrupt enable mask block.
// Assumes the AXI4-Lite timing and pulse events described for the block.
`include "irq_mask_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h expected %h", $time, a, e); end end

module test_interrupt_enable_mask;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, core_irq_accept, core_irq, core_vector_valid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, lag = 0;
  logic [11:0] core_vector;
  logic [7:0] ev = 0, flags = 0, en = 0;
  int err_total = 0, tests_run = 0, seed = 32'hb3d1;

  // ****************
  // Clock, parts
  // ****************
  initial forever #25 clock = ~clock;
  interrupt_enable_mask u_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_bus_event(ev[7]),
    .touch_key_event(ev[6]), .second_timer_event(ev[5]), .first_timer_event(ev[4]),
    .wakeup_timer_event(ev[3]), .ext_pin_c_irq(ev[2]), .ext_pin_b_irq(ev[1]),
    .ext_pin_a_irq(ev[0]), .core_irq, .core_irq_accept, .core_vector, .core_vector_valid);
  core_model u_core (.clock, .rst, .core_irq, .core_vector_valid, .lag, .core_irq_accept);

  // Vector is the shared entry only in the cycle after an accept; looked at mid-cycle
  logic took = 0;
  always @(negedge clock)
  begin
    if (!rst)
    begin
      `CHK(core_vector_valid, took)
      `CHK(core_vector, took ? `SHARED_IRQ_VECTOR : `RESET_VECTOR)
    end
    took = !rst && core_irq && core_irq_accept;
  end

  task finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait on a sampled flag; a hang counts as a mismatch
  task hang_check(input int n);
    if (n >= 40)
    begin
      err_total++;
      $display("[ERR] %0t bus handshake timed out", $time);
      finish_test();
    end
  endtask

  // ****************
  // Bus cycles
  // ****************
  task axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ra, rw, ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40 && !(ta && tw); n++)
    begin
      @(negedge clock);
      ra = s_axi_awready && s_axi_awvalid;
      rw = s_axi_wready && s_axi_wvalid;
      @(posedge clock);
      if (ra) s_axi_awvalid <= 0;
      if (rw) s_axi_wvalid <= 0;
      ta |= ra;
      tw |= rw;
    end
    hang_check(n);
    for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++)
      @(negedge clock);
    hang_check(n);
    `CHK(s_axi_bresp, er)
    @(posedge clock);
    s_axi_bready <= 0;
  endtask

  task axi_rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40 && s_axi_arready !== 1'b1; n++)
      @(negedge clock);
    hang_check(n);
    @(posedge clock);
    s_axi_arvalid <= 0;
    for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n++)
      @(negedge clock);
    hang_check(n);
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    @(posedge clock);
    s_axi_rready <= 0;
  endtask

  // One pass: set enables, fire events, check request, then clear by writing zeros
  task run(input logic [7:0] e, input logic [7:0] v, input logic [7:0] clr);
    lag <= $random(seed);
    axi_wr(`ENABLE_ADDR, {24'($random(seed)), e}, `RESP_OKAY);
    en = e;
    axi_rd(`ENABLE_ADDR, {24'h0, en}, `RESP_OKAY);
    @(posedge clock);
    ev <= v;
    @(posedge clock);
    ev <= 0;
    flags = flags | v;
    @(posedge clock);
    #1;
    `CHK(core_irq, |(flags & en))
    axi_rd(`PENDING_ADDR, {24'h0, flags}, `RESP_OKAY);
    axi_wr(`PENDING_ADDR, {24'h0, clr}, `RESP_OKAY);
    flags = flags & clr;
    axi_rd(`PENDING_ADDR, {24'h0, flags}, `RESP_OKAY);
    repeat (2) @(posedge clock);
    #1;
    `CHK(core_irq, |(flags & en))
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    logic [7:0] tab [6][2];
    tab = '{'{8'h40, 8'hBF}, '{8'h40, 8'h40}, '{8'h04, 8'hFB}, '{8'h04, 8'h04},
      '{8'h02, 8'hFD}, '{8'h02, 8'h02}};
    repeat (2) @(posedge clock);
    rst <= 0;
    axi_rd(`ENABLE_ADDR, 32'h0, `RESP_OKAY);
    axi_rd(`PENDING_ADDR, 32'h0, `RESP_OKAY);
    axi_wr(14'h0100, 32'hFF, `RESP_SLVERR);
    axi_rd(14'h0100, 32'h0, `RESP_SLVERR);
    // Low lane strobe off: write answered but enable stays zero
    s_axi_wstrb <= 4'hE;
    axi_wr(`ENABLE_ADDR, 32'hFF, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(`ENABLE_ADDR, 32'h0, `RESP_OKAY);
    $display("test reset and unmapped done");
    foreach (tab[i])
      run(tab[i][0], tab[i][1], 8'h00);
    $display("test gating corners done");
    repeat (30)
      run($random(seed), $random(seed), $random(seed));
    $display("test random passes done");
    finish_test();
  end
endmodule
